// ===== design/cls_pkg.sv
// Constants, modes and functions shared by the configurable logic slice.
// Assumes one fabric clock; every user of this package names it cls_pkg::.
// Functional notes
// - Slice works in logic, ripple, RAM or ROM mode.
// - Each four-input table gives any function from 16 programmed entries.
// - Both tables of one slice combine into a five-input table.
// - Six to eight inputs chain several slices; eight needs over four.
// - Ripple mode adds, subtracts, or adds/subtracts under dynamic control, 2 bits.
// - Ripple mode counts 2 bits up, down or up/down; async clear anytime.
// - Up/down counter loads a preset on the clock edge when asked.
// - Ripple mode compares A with B: greater-equal, not-equal, less-equal.
// - Ripple mode offers a multiplier building block.
// - Fast-carry configuration emits carry-generate and carry-propagate per slice.
// - RAM mode forms 16x4 single-port memory from 16x1 table columns.
// - Address and write control are shared by all storage columns.
// - Pseudo two-port memory adds an independent read-only port.
// - Single-port and pseudo two-port 16x4 memories each take three slices.
// - Memory contents load initial values at configuration time.
package cls_pkg;
	localparam int TBL_IN_W = 4;
	localparam int TBL_ENTRIES = 16;
	localparam int ARITH_W = 2;
	localparam int MEM_ADDR_W = 4;
	localparam int MEM_DEPTH = 16;
	localparam int MEM_DATA_W = 4;
	localparam int MEM_SLICES = 3;
	localparam logic [ARITH_W-1:0] CNT_RESET = 2'h0;
	localparam logic [MEM_DEPTH*MEM_DATA_W-1:0] MEM_INIT = 64'h0000_0000_0000_0000;

	typedef enum logic [1:0] {
		MODE_LOGIC,
		MODE_RIPPLE,
		MODE_RAM,
		MODE_ROM
	} cls_mode_t;

	typedef enum logic [2:0] {
		FN_ADD,
		FN_SUB,
		FN_ADDSUB,
		FN_UP,
		FN_DOWN,
		FN_UPDOWN,
		FN_CMP,
		FN_MULT
	} cls_fn_t;
endpackage

// ===== design/cls_mem_if.sv
// Port bundle between the slice control and its distributed memory.
// Assumes write and read addresses come from the controlling slice.
`timescale 1ns/1ps
`default_nettype none
interface cls_mem_if;
	logic we;
	logic [cls_pkg::MEM_ADDR_W-1:0] addr;
	logic [cls_pkg::MEM_DATA_W-1:0] wdata;
	logic [cls_pkg::MEM_ADDR_W-1:0] rd_addr;
	logic [cls_pkg::MEM_DATA_W-1:0] rdata;
	logic [cls_pkg::MEM_DATA_W-1:0] rdata_b;
	modport ctl (output we, output addr, output wdata, output rd_addr,
		input rdata, input rdata_b);
	modport mem (input we, input addr, input wdata, input rd_addr,
		output rdata, output rdata_b);
endinterface
`default_nettype wire

// ===== design/cls_dist_mem.sv
// Distributed 16x4 memory built from 16x1 columns, with a second read port.
// Assumes rst stands for configuration load; reads are combinational.
`timescale 1ns/1ps
`default_nettype none
module cls_dist_mem #(
	parameter logic [cls_pkg::MEM_DEPTH*cls_pkg::MEM_DATA_W-1:0] INIT = cls_pkg::MEM_INIT
) (
	input wire logic ref_clk,
	input wire logic rst,
	cls_mem_if.mem bus
);
	genvar gi;
	generate
		for (gi = 0; gi < cls_pkg::MEM_DATA_W; gi++) begin : g_col
			logic [cls_pkg::MEM_DEPTH-1:0] col_ff;
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					col_ff <= INIT[gi*cls_pkg::MEM_DEPTH +: cls_pkg::MEM_DEPTH];
				end else if (bus.we) begin
					col_ff[bus.addr] <= bus.wdata[gi];
				end
			end
			assign bus.rdata[gi] = col_ff[bus.addr];
			assign bus.rdata_b[gi] = col_ff[bus.rd_addr];
		end
	endgenerate
endmodule // cls_dist_mem
`default_nettype wire

// ===== design/cls_slice.sv
// Configurable logic slice: tables, ripple arithmetic, counter, memory.
// Assumes all inputs synchronous to ref_clk except the counter clear.
`timescale 1ns/1ps
`default_nettype none
module cls_slice (
	input wire logic ref_clk,
	input wire logic rst,
	input wire cls_pkg::cls_mode_t mode,
	input wire cls_pkg::cls_fn_t ripple_fn,
	input wire logic [cls_pkg::TBL_ENTRIES-1:0] table_cfg0,
	input wire logic [cls_pkg::TBL_ENTRIES-1:0] table_cfg1,
	input wire logic [cls_pkg::TBL_IN_W-1:0] tbl_in,
	input wire logic tbl_sel,
	input wire logic chain_in,
	input wire logic chain_sel,
	input wire logic [cls_pkg::ARITH_W-1:0] op_a,
	input wire logic [cls_pkg::ARITH_W-1:0] op_b,
	input wire logic carry_in,
	input wire logic sub_sel,
	input wire logic mult_bit,
	input wire logic cnt_en,
	input wire logic cnt_up,
	input wire logic cnt_clr,
	input wire logic cnt_load,
	input wire logic [cls_pkg::ARITH_W-1:0] cnt_preset,
	input wire logic mem_we,
	input wire logic [cls_pkg::MEM_ADDR_W-1:0] mem_addr,
	input wire logic [cls_pkg::MEM_ADDR_W-1:0] mem_rd_addr,
	input wire logic [cls_pkg::MEM_DATA_W-1:0] mem_wdata,
	output logic tbl_out0_ff,
	output logic tbl_out1_ff,
	output logic five_out_ff,
	output logic wide_out_ff,
	output logic [cls_pkg::ARITH_W-1:0] sum_ff,
	output logic carry_out_ff,
	output logic carry_gen_ff,
	output logic carry_prop_ff,
	output logic [cls_pkg::ARITH_W-1:0] count_ff,
	output logic cmp_ge_ff,
	output logic cmp_ne_ff,
	output logic cmp_le_ff,
	output logic [cls_pkg::MEM_DATA_W-1:0] mem_rdata_ff,
	output logic [cls_pkg::MEM_DATA_W-1:0] mem_rdata_b_ff
);
	cls_mem_if mem_if ();

	logic is_logic;
	logic is_ripple;
	logic is_mem;
	logic nxt_tbl0;
	logic nxt_tbl1;
	logic nxt_five;
	logic do_sub;
	logic is_arith;
	logic is_count;
	logic [cls_pkg::ARITH_W-1:0] eff_b;
	logic [cls_pkg::ARITH_W:0] full_sum;
	logic [cls_pkg::ARITH_W-1:0] bit_gen;
	logic [cls_pkg::ARITH_W-1:0] bit_prop;
	logic blk_gen;
	logic blk_prop;

	assign is_logic = (mode == cls_pkg::MODE_LOGIC);
	assign is_ripple = (mode == cls_pkg::MODE_RIPPLE);
	assign is_mem = (mode == cls_pkg::MODE_RAM) || (mode == cls_pkg::MODE_ROM);

	assign nxt_tbl0 = table_cfg0[tbl_in];
	assign nxt_tbl1 = table_cfg1[tbl_in];
	assign nxt_five = tbl_sel ? nxt_tbl1 : nxt_tbl0;

	always_ff @(posedge ref_clk) begin
		if (rst || !is_logic) begin
			tbl_out0_ff <= 1'b0;
			tbl_out1_ff <= 1'b0;
			five_out_ff <= 1'b0;
			wide_out_ff <= 1'b0;
		end else begin
			tbl_out0_ff <= nxt_tbl0;
			tbl_out1_ff <= nxt_tbl1;
			five_out_ff <= nxt_five;
			wide_out_ff <= chain_sel ? chain_in : nxt_five;
		end
	end

	assign do_sub = (ripple_fn == cls_pkg::FN_SUB) ||
		((ripple_fn == cls_pkg::FN_ADDSUB) && sub_sel);
	assign is_arith = (ripple_fn == cls_pkg::FN_ADD) || (ripple_fn == cls_pkg::FN_SUB) ||
		(ripple_fn == cls_pkg::FN_ADDSUB) || (ripple_fn == cls_pkg::FN_MULT);
	assign is_count = (ripple_fn == cls_pkg::FN_UP) || (ripple_fn == cls_pkg::FN_DOWN) ||
		(ripple_fn == cls_pkg::FN_UPDOWN);

	// Subtract is a + ~b + carry_in; chain bottom must feed carry_in high
	always_comb begin
		if (ripple_fn == cls_pkg::FN_MULT) begin
			eff_b = op_b & {cls_pkg::ARITH_W{mult_bit}};
		end else if (do_sub) begin
			eff_b = ~op_b;
		end else begin
			eff_b = op_b;
		end
	end

	assign full_sum = {1'b0, op_a} + {1'b0, eff_b} + {{cls_pkg::ARITH_W{1'b0}}, carry_in};

	assign bit_gen = op_a & eff_b;
	assign bit_prop = op_a ^ eff_b;
	assign blk_gen = bit_gen[1] | (bit_prop[1] & bit_gen[0]);
	assign blk_prop = &bit_prop;

	always_ff @(posedge ref_clk) begin
		if (rst || !is_ripple || !is_arith) begin
			sum_ff <= '0;
			carry_out_ff <= 1'b0;
			carry_gen_ff <= 1'b0;
			carry_prop_ff <= 1'b0;
		end else begin
			sum_ff <= full_sum[cls_pkg::ARITH_W-1:0];
			carry_out_ff <= full_sum[cls_pkg::ARITH_W];
			carry_gen_ff <= blk_gen;
			carry_prop_ff <= blk_prop;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !is_ripple || (ripple_fn != cls_pkg::FN_CMP)) begin
			cmp_ge_ff <= 1'b0;
			cmp_ne_ff <= 1'b0;
			cmp_le_ff <= 1'b0;
		end else begin
			cmp_ge_ff <= (op_a >= op_b);
			cmp_ne_ff <= (op_a != op_b);
			cmp_le_ff <= (op_a <= op_b);
		end
	end

	// Clear is asynchronous by design; it must not glitch in use
	// counter with async clear
	always_ff @(posedge ref_clk or posedge cnt_clr) begin
		if (cnt_clr) begin
			count_ff <= cls_pkg::CNT_RESET;
		end else if (rst) begin
			count_ff <= cls_pkg::CNT_RESET;
		end else if (is_ripple && is_count) begin
			if (cnt_load) begin
				count_ff <= cnt_preset;
			end else if (cnt_en) begin
				case (ripple_fn)
					cls_pkg::FN_UP: count_ff <= count_ff + 2'h1;
					cls_pkg::FN_DOWN: count_ff <= count_ff - 2'h1;
					cls_pkg::FN_UPDOWN: count_ff <= cnt_up ? count_ff + 2'h1 : count_ff - 2'h1;
					default: count_ff <= count_ff;
				endcase
			end
		end
	end

	assign mem_if.we = mem_we && (mode == cls_pkg::MODE_RAM);
	assign mem_if.addr = mem_addr;
	assign mem_if.wdata = mem_wdata;
	assign mem_if.rd_addr = mem_rd_addr;

	cls_dist_mem #(
		.INIT(cls_pkg::MEM_INIT)
	) u_mem (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus(mem_if.mem)
	);

	// Output flop adds one cycle to the combinational array read
	always_ff @(posedge ref_clk) begin
		if (rst || !is_mem) begin
			mem_rdata_ff <= '0;
			mem_rdata_b_ff <= '0;
		end else begin
			mem_rdata_ff <= mem_if.rdata;
			mem_rdata_b_ff <= mem_if.rdata_b;
		end
	end

	// Reference sum kept apart from the datapath
	logic [cls_pkg::ARITH_W:0] add_ref;
	assign add_ref = {1'b0, op_a} + {1'b0, op_b} + {{cls_pkg::ARITH_W{1'b0}}, carry_in};

	a_tbl_lookup: assert property (@(posedge ref_clk) disable iff (rst)
		is_logic |=> tbl_out0_ff == $past(table_cfg0[tbl_in]) &&
			tbl_out1_ff == $past(table_cfg1[tbl_in]))
		else $error("table output does not match programmed entry");

	a_five_select: assert property (@(posedge ref_clk) disable iff (rst)
		is_logic |=> five_out_ff == ($past(tbl_sel) ? tbl_out1_ff : tbl_out0_ff))
		else $error("five-input table selects wrong half");

	a_wide_chain: assert property (@(posedge ref_clk) disable iff (rst)
		(is_logic && chain_sel) |=> wide_out_ff == $past(chain_in))
		else $error("chained input not passed to wide output");

	a_add_result: assert property (@(posedge ref_clk) disable iff (rst)
		(is_ripple && ripple_fn == cls_pkg::FN_ADD) |=>
			{carry_out_ff, sum_ff} == $past(add_ref))
		else $error("two-bit add result wrong");

	a_sub_result: assert property (@(posedge ref_clk) disable iff (rst)
		(is_ripple && ripple_fn == cls_pkg::FN_ADDSUB && sub_sel && carry_in) |=>
			sum_ff == $past(op_a - op_b))
		else $error("dynamic subtract result wrong");

	a_cnt_clear: assert property (@(posedge ref_clk) disable iff (rst)
		cnt_clr |-> count_ff == cls_pkg::CNT_RESET)
		else $error("counter not cleared while clear held");

	a_cnt_step: assert property (@(posedge ref_clk) disable iff (rst || cnt_clr)
		(is_ripple && ripple_fn == cls_pkg::FN_UP && cnt_en && !cnt_load) ##1 !cnt_clr
			|-> count_ff == $past(count_ff) + 2'h1)
		else $error("up counter did not advance by one");

	a_cnt_preload: assert property (@(posedge ref_clk) disable iff (rst || cnt_clr)
		(is_ripple && is_count && cnt_load) ##1 !cnt_clr |-> count_ff == $past(cnt_preset))
		else $error("counter preload not taken");

	a_cmp_flags: assert property (@(posedge ref_clk) disable iff (rst)
		(is_ripple && ripple_fn == cls_pkg::FN_CMP) |=>
			(cmp_ge_ff || cmp_le_ff) && (cmp_ne_ff == !(cmp_ge_ff && cmp_le_ff)) &&
			cmp_ge_ff == ($past(op_a) >= $past(op_b)))
		else $error("comparator flags inconsistent");

	a_mult_gate: assert property (@(posedge ref_clk) disable iff (rst)
		(is_ripple && ripple_fn == cls_pkg::FN_MULT && !mult_bit && !carry_in) |=>
			sum_ff == $past(op_a) && !carry_out_ff)
		else $error("multiplier gate passed operand b");

	a_carry_gp: assert property (@(posedge ref_clk) disable iff (rst)
		(is_ripple && is_arith) |=>
			carry_out_ff == (carry_gen_ff || (carry_prop_ff && $past(carry_in))))
		else $error("carry generate or propagate wrong");

	a_rom_nowrite: assert property (@(posedge ref_clk) disable iff (rst)
		(mode == cls_pkg::MODE_ROM) |-> !mem_if.we)
		else $error("write reached memory in read-only mode");

	a_mem_write: assert property (@(posedge ref_clk) disable iff (rst)
		mem_if.we ##1 (!mem_if.we && mode == cls_pkg::MODE_RAM && mem_addr == $past(mem_addr))
			|=> mem_rdata_ff == $past(mem_wdata, 2))
		else $error("written word not read back");

	a_pdp_read: assert property (@(posedge ref_clk) disable iff (rst)
		(is_mem && mem_rd_addr == mem_addr) |=> mem_rdata_b_ff == mem_rdata_ff)
		else $error("read-only port disagrees with main port");

	a_wide_own: assert property (@(posedge ref_clk) disable iff (rst)
		(is_logic && !chain_sel) |=> wide_out_ff == five_out_ff)
		else $error("unchained wide output differs from five-input table");

	a_logic_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!is_logic |=> !tbl_out0_ff && !tbl_out1_ff && !five_out_ff && !wide_out_ff)
		else $error("table outputs active outside logic mode");

	a_ripple_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!is_ripple |=> sum_ff == '0 && !carry_out_ff && !carry_gen_ff && !carry_prop_ff &&
			!cmp_ge_ff && !cmp_ne_ff && !cmp_le_ff)
		else $error("ripple outputs active outside ripple mode");

	a_mem_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!is_mem |=> mem_rdata_ff == '0 && mem_rdata_b_ff == '0)
		else $error("memory read data active outside memory modes");

	a_cnt_hold: assert property (@(posedge ref_clk) disable iff (rst || cnt_clr)
		!(is_ripple && is_count) ##1 !cnt_clr |-> count_ff == $past(count_ff))
		else $error("counter moved outside counting functions");

	a_cnt_down: assert property (@(posedge ref_clk) disable iff (rst || cnt_clr)
		(is_ripple && ripple_fn == cls_pkg::FN_DOWN && cnt_en && !cnt_load) ##1 !cnt_clr
			|-> count_ff == $past(count_ff) - 2'h1)
		else $error("down counter did not step back by one");

	a_mult_pass: assert property (@(posedge ref_clk) disable iff (rst)
		(is_ripple && ripple_fn == cls_pkg::FN_MULT && mult_bit) |=>
			{carry_out_ff, sum_ff} == $past(add_ref))
		else $error("multiplier gate blocked operand b");

	c_add_carry: cover property (@(posedge ref_clk) disable iff (rst)
		is_ripple && ripple_fn == cls_pkg::FN_ADD ##1 carry_out_ff);
	c_cnt_wrap: cover property (@(posedge ref_clk) disable iff (rst || cnt_clr)
		count_ff == 2'h3 ##1 count_ff == 2'h0);
	c_mem_rw: cover property (@(posedge ref_clk) disable iff (rst)
		mem_if.we ##1 !mem_if.we ##1 mem_rdata_ff != '0);
	c_five_hi: cover property (@(posedge ref_clk) disable iff (rst)
		is_logic && tbl_sel ##1 five_out_ff);
	c_cnt_load: cover property (@(posedge ref_clk) disable iff (rst || cnt_clr)
		is_ripple && is_count && cnt_load ##1 count_ff == $past(cnt_preset));
endmodule // cls_slice
`default_nettype wire

// ===== tb/cls_nbr_model.sv
// Neighbour slice model that feeds the chain input of the slice.
// Assumes the bench changes nbr_val on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module cls_nbr_model (
	input wire logic ref_clk,
	input wire logic nbr_val,
	output logic chain_out_ff
);
	// chained slice output
	// Registered like a real slice, so it lands one cycle late
	always_ff @(posedge ref_clk) begin
		chain_out_ff <= nbr_val;
	end
endmodule // cls_nbr_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the configurable logic slice.
// Assumes every slice output follows its inputs one rising edge later, except count_ff, which cnt_clr clears at once.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk, rst, tbl_sel, chain_sel, carry_in, sub_sel, mult_bit, nbr_val, chain_in;
	logic cnt_en, cnt_up, cnt_clr, cnt_load, mem_we;
	cls_pkg::cls_mode_t mode;
	cls_pkg::cls_fn_t ripple_fn;
	logic [15:0] table_cfg0, table_cfg1;
	logic [3:0] tbl_in, mem_addr, mem_rd_addr, mem_wdata, mem_rdata_ff, mem_rdata_b_ff;
	logic [1:0] op_a, op_b, cnt_preset, sum_ff, count_ff;
	logic tbl_out0_ff, tbl_out1_ff, five_out_ff, wide_out_ff, carry_out_ff;
	logic carry_gen_ff, carry_prop_ff, cmp_ge_ff, cmp_ne_ff, cmp_le_ff;
	int err_total, num_checks, cycles;

	cls_slice dut (.ref_clk, .rst, .mode, .ripple_fn, .table_cfg0, .table_cfg1, .tbl_in,
		.tbl_sel, .chain_in, .chain_sel, .op_a, .op_b, .carry_in, .sub_sel, .mult_bit,
		.cnt_en, .cnt_up, .cnt_clr, .cnt_load, .cnt_preset, .mem_we, .mem_addr,
		.mem_rd_addr, .mem_wdata, .tbl_out0_ff, .tbl_out1_ff, .five_out_ff, .wide_out_ff,
		.sum_ff, .carry_out_ff, .carry_gen_ff, .carry_prop_ff, .count_ff, .cmp_ge_ff,
		.cmp_ne_ff, .cmp_le_ff, .mem_rdata_ff, .mem_rdata_b_ff);
	cls_nbr_model nbr (.ref_clk(ref_clk), .nbr_val(nbr_val), .chain_out_ff(chain_in));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Cuts a hang well past the few hundred cycles needed
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic step();
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic t_logic();
		int i;
		logic prev;
		prev = 1'b0;
		mode = cls_pkg::MODE_LOGIC;
		table_cfg0 = 16'h6996;
		table_cfg1 = 16'h8001;
		for (i = 0; i < 16; i++) begin
			tbl_in = i[3:0];
			tbl_sel = i[2];
			chain_sel = i[3];
			nbr_val = i[1];
			step();
			chk({tbl_out1_ff, tbl_out0_ff}, {table_cfg1[i], table_cfg0[i]});
			chk(five_out_ff, tbl_sel ? table_cfg1[i] : table_cfg0[i]);
			chk(wide_out_ff, chain_sel ? prev : (tbl_sel ? table_cfg1[i] : table_cfg0[i]));
			chk({sum_ff, carry_out_ff, cmp_ge_ff, mem_rdata_ff}, 8'h00);
			prev = i[1];
		end
	endtask

	task automatic t_arith();
		int k, j;
		logic [1:0] eb, g, p;
		logic [2:0] s;
		cls_pkg::cls_fn_t fns[6] = '{cls_pkg::FN_ADD, cls_pkg::FN_SUB, cls_pkg::FN_ADDSUB,
			cls_pkg::FN_ADDSUB, cls_pkg::FN_MULT, cls_pkg::FN_MULT};
		mode = cls_pkg::MODE_RIPPLE;
		for (k = 0; k < 6; k++) begin
			ripple_fn = fns[k];
			sub_sel = (k == 3);
			mult_bit = (k == 5);
			for (j = 0; j < 32; j++) begin
				op_a = j[4:3];
				op_b = j[2:1];
				carry_in = j[0];
				eb = (k == 1 || k == 3) ? ~op_b : (k == 4 ? 2'h0 : op_b);
				s = op_a + eb + carry_in;
				g = op_a & eb;
				p = op_a ^ eb;
				step();
				chk({carry_out_ff, sum_ff}, s);
				chk({carry_gen_ff, carry_prop_ff}, {g[1] | p[1] & g[0], p[1] & p[0]});
			end
		end
	endtask

	task automatic t_cmp();
		int j;
		ripple_fn = cls_pkg::FN_CMP;
		for (j = 0; j < 16; j++) begin
			op_a = j[3:2];
			op_b = j[1:0];
			step();
			chk({cmp_ge_ff, cmp_ne_ff, cmp_le_ff}, {op_a >= op_b, op_a != op_b, op_a <= op_b});
		end
	endtask

	task automatic t_count();
		int k, n;
		logic [1:0] exp;
		cls_pkg::cls_fn_t fns[4] = '{cls_pkg::FN_UP, cls_pkg::FN_DOWN, cls_pkg::FN_UPDOWN,
			cls_pkg::FN_UPDOWN};
		exp = 2'h0;
		cnt_en = 1'b1;
		for (k = 0; k < 4; k++) begin
			ripple_fn = fns[k];
			cnt_up = (k == 2);
			for (n = 0; n < 4; n++) begin
				step();
				exp = (k == 0 || k == 2) ? exp + 2'h1 : exp - 2'h1;
				chk(count_ff, exp);
			end
		end
		cnt_load = 1'b1;
		cnt_preset = 2'h2;
		step();
		chk(count_ff, 8'h02);
		cnt_load = 1'b0;
		ripple_fn = cls_pkg::FN_ADD;
		step();
		chk(count_ff, 8'h02);
		ripple_fn = cls_pkg::FN_UP;
		cnt_clr = 1'b1;
		#1;
		chk(count_ff, 8'h00);
		step();
		chk(count_ff, 8'h00);
		cnt_clr = 1'b0;
		cnt_en = 1'b0;
	endtask

	task automatic t_mem();
		int i;
		mode = cls_pkg::MODE_RAM;
		mem_addr = 4'h3;
		step();
		chk(mem_rdata_ff, 8'h00);
		mem_we = 1'b1;
		for (i = 0; i < 16; i++) begin
			mem_addr = i[3:0];
			mem_wdata = i[3:0] ^ 4'ha;
			step();
			chk(mem_rdata_ff, 8'h00);
		end
		mem_we = 1'b0;
		for (i = 0; i < 16; i++) begin
			mem_addr = i[3:0];
			mem_rd_addr = 4'(15 - i);
			step();
			chk(mem_rdata_ff, i[3:0] ^ 4'ha);
			chk(mem_rdata_b_ff, 4'(15 - i) ^ 4'ha);
		end
		mem_we = 1'b1;
		mem_addr = 4'h5;
		mem_wdata = 4'h3;
		step();
		chk(mem_rdata_ff, 8'h0f);
		mem_we = 1'b0;
		step();
		chk(mem_rdata_ff, 8'h03);
		mode = cls_pkg::MODE_ROM;
		mem_we = 1'b1;
		mem_addr = 4'h0;
		mem_wdata = 4'hf;
		step();
		mem_we = 1'b0;
		step();
		chk(mem_rdata_ff, 8'h0a);
	endtask

	initial begin
		{rst, tbl_sel, chain_sel, carry_in, sub_sel, mult_bit, nbr_val} = 7'h40;
		{cnt_en, cnt_up, cnt_clr, cnt_load, mem_we} = 5'h00;
		mode = cls_pkg::MODE_LOGIC;
		ripple_fn = cls_pkg::FN_ADD;
		{table_cfg0, table_cfg1} = 32'h0000_0000;
		{tbl_in, mem_addr, mem_rd_addr, mem_wdata} = 16'h0000;
		{op_a, op_b, cnt_preset} = 6'h00;
		{err_total, num_checks, cycles} = 3'h0;
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		chk({count_ff, sum_ff, mem_rdata_ff}, 8'h00);
		t_logic();
		t_arith();
		t_cmp();
		t_count();
		t_mem();
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
